/* fsr_pkg.sv */
package fsr_pkg;
   localparam logic [7:0] FSR_ADDR       = 8'h21;
   localparam int         BIT_OV         = 0;
   localparam int         BIT_UV         = 1;
   localparam int         BIT_CRC        = 2;
   localparam int         BIT_POR        = 3;
   localparam int         BIT_FORCE      = 4;
   localparam int         BIT_IFAULT     = 5;
   localparam logic [7:0] FSR_W1C_MASK   = 8'h2F;
   localparam logic [7:0] FSR_USED_MASK  = 8'h3F;
   localparam logic [7:0] FSR_RESET_VAL  = 8'h08;
   localparam logic [7:0] FSR_ZERO       = 8'h00;

   typedef struct packed {
      logic consistencyFail;
      logic crcError;
      logic cell_undervoltage_flag;
      logic cell_overvoltage_flag;
   } fsr_events_t;

   typedef struct packed {
      logic       wrEn;
      logic       rdEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } fsr_req_t;
endpackage

/* fsr_reg_core.sv */
`timescale 1ns/1ns
module fsr_reg_core
   import fsr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        porDone,
   input  fsr_pkg::fsr_events_t events,
   input  wire logic        hit,
   input  wire logic        wrEn,
   input  wire logic [7:0]  wrData,
   output logic [7:0]       status
);
   logic [7:0] next_status;
   logic [7:0] setBits;

   always_comb begin
      setBits                 = FSR_ZERO;
      setBits[BIT_OV]         = events.cell_overvoltage_flag;   // RQ10
      setBits[BIT_UV]         = events.cell_undervoltage_flag;  // RQ9
      setBits[BIT_CRC]        = events.crcError;                // RQ8
      setBits[BIT_IFAULT]     = events.consistencyFail;         // RQ4
      setBits[BIT_POR]        = porDone;                        // RQ6
      next_status = status;
      if (hit && wrEn) begin
         // clear first so a same-cycle event still wins
         next_status = next_status & ~(wrData & FSR_W1C_MASK);  // RQ1
         next_status[BIT_FORCE] = wrData[BIT_FORCE];            // RQ2
      end
      next_status = (next_status | setBits) & FSR_USED_MASK;    // RQ12
   end

   // por flag starts clear; it is raised once the load sequence finishes
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         status <= FSR_ZERO;
      end else begin
         status <= next_status;
      end
   end
endmodule

/* fsr_fault_status.sv */
`timescale 1ns/1ns
// How it works
// RQ1: each fault flag stays set until the host writes a one to its bit, which clears it.
// RQ2: bit 4 is a plain read/write control bit, written with one or zero.
// RQ3: while bit 4 is one the fault output is asserted, and at zero it adds nothing.
// RQ4: bit 5 is set when the internal register consistency check fails.
// RQ5: the host should reset the device on a consistency failure and give up if it returns.
// RQ6: bit 3 is set by every power-on reset and held until the host clears it.
// RQ7: after power-on the register groups are loaded before the reset flag is raised.
// RQ8: bit 2 is set when a received packet has a checksum error.
// RQ9: bit 1 is set when any cell is below the undervoltage threshold.
// RQ10: bit 0 is set when any cell is over the overvoltage threshold.
// RQ11: the fault output is high whenever any flag or the force bit is set.
// RQ12: bits 7 and 6 read as zero and ignore writes.
module fsr_fault_status
   import fsr_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          reset,
   input  fsr_pkg::fsr_req_t  req,
   input  fsr_pkg::fsr_events_t events,
   input  wire logic          groupLoadDone,
   output logic               groupLoadStart,
   output logic [7:0]         rdData,
   output logic               rdValid,
   output logic               faultOut
);
   typedef enum logic [2:0] {
      ST_LOAD = 3'b001,
      ST_WAIT = 3'b010,
      ST_RUN  = 3'b100
   } fsr_state_t;

   fsr_state_t state;
   fsr_state_t next_state;
   logic       porDone;
   logic       next_groupLoadStart;
   logic [7:0] status;
   logic [7:0] next_rdData;
   logic       next_rdValid;
   logic       next_faultOut;
   logic       hit;

   assign hit = (req.addr == FSR_ADDR);

   // power-on sequence: request group load, wait for done, then flag por
   always_comb begin
      next_state          = state;
      next_groupLoadStart = 1'b0;
      porDone             = 1'b0;
      case (state)
         ST_LOAD: begin
            next_groupLoadStart = 1'b1;
            next_state          = ST_WAIT;
         end
         ST_WAIT: begin
            if (groupLoadDone) begin
               porDone    = 1'b1; // RQ7
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            next_state = ST_RUN;
         end
         default: begin
            next_state = ST_LOAD;
         end
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state          <= ST_LOAD;
         groupLoadStart <= 1'b0;
      end else begin
         state          <= next_state;
         groupLoadStart <= next_groupLoadStart;
      end
   end

   fsr_reg_core u_core (
      .clk     (clk),
      .reset   (reset),
      .porDone (porDone),
      .events  (events),
      .hit     (hit),
      .wrEn    (req.wrEn),
      .wrData  (req.wrData),
      .status  (status)
   );

   // reserved bits are masked on both paths so a stray upper bit can never leak out
   function automatic logic [7:0] visibleBits(input logic [7:0] value);
      return value & FSR_USED_MASK;
   endfunction

   always_comb begin
      next_rdValid  = req.rdEn;
      next_rdData   = (req.rdEn && hit) ? visibleBits(status) : FSR_ZERO; // RQ12
      // any sticky flag or the force bit drives the line
      next_faultOut = |visibleBits(status); // RQ3 RQ11
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdData   <= FSR_ZERO;
         rdValid  <= 1'b0;
         faultOut <= 1'b0;
      end else begin
         rdData   <= next_rdData;
         rdValid  <= next_rdValid;
         faultOut <= next_faultOut;
      end
   end

   chk_flag_sticky: assert property (@(posedge clk) disable iff (reset) // RQ1
      ($past(status[BIT_OV]) && !($past(req.wrEn) && $past(hit) && $past(req.wrData[BIT_OV])))
      |-> status[BIT_OV])
      else $error("overvoltage flag dropped without a clearing write");

   chk_w1c_clear: assert property (@(posedge clk) disable iff (reset) // RQ1
      (req.wrEn && hit && req.wrData[BIT_CRC] && !events.crcError) |=> !status[BIT_CRC])
      else $error("checksum flag not cleared by write of one");

   chk_force_rw: assert property (@(posedge clk) disable iff (reset) // RQ2
      (req.wrEn && hit) |=> (status[BIT_FORCE] == $past(req.wrData[BIT_FORCE])))
      else $error("force bit does not hold written value");

   chk_force_fault: assert property (@(posedge clk) disable iff (reset) // RQ3
      status[BIT_FORCE] |=> faultOut)
      else $error("force bit did not assert fault output");

   chk_ifault_set: assert property (@(posedge clk) disable iff (reset) // RQ4
      events.consistencyFail |=> status[BIT_IFAULT])
      else $error("consistency flag not set");

   sequence seqLoadDone;
      (state == ST_WAIT) && groupLoadDone;
   endsequence
   chk_por_after_load: assert property (@(posedge clk) disable iff (reset) // RQ6 RQ7
      seqLoadDone |=> status[BIT_POR] ##1 (status[BIT_POR] || $past(req.wrEn && hit)))
      else $error("por flag not raised after group load");

   chk_crc_set: assert property (@(posedge clk) disable iff (reset) // RQ8
      events.crcError |=> status[BIT_CRC])
      else $error("checksum flag not set");

   chk_uv_set: assert property (@(posedge clk) disable iff (reset) // RQ9
      events.cell_undervoltage_flag |=> status[BIT_UV])
      else $error("undervoltage flag not set");

   chk_ov_set: assert property (@(posedge clk) disable iff (reset) // RQ10
      events.cell_overvoltage_flag |=> status[BIT_OV])
      else $error("overvoltage flag not set");

   chk_fault_follow: assert property (@(posedge clk) disable iff (reset) // RQ11
      ##1 (faultOut == (|$past(status))))
      else $error("fault output does not follow flags");

   chk_reserved_zero: assert property (@(posedge clk) disable iff (reset) // RQ12
      (status[7:6] == 2'b00) && (rdData[7:6] == 2'b00))
      else $error("reserved bits not zero");

   chk_uv_sticky: assert property (@(posedge clk) disable iff (reset) // RQ1
      (status[BIT_UV] && !(req.wrEn && hit && req.wrData[BIT_UV])) |=> status[BIT_UV])
      else $error("undervoltage flag dropped without a clearing write");

   chk_crc_sticky: assert property (@(posedge clk) disable iff (reset) // RQ1
      (status[BIT_CRC] && !(req.wrEn && hit && req.wrData[BIT_CRC])) |=> status[BIT_CRC])
      else $error("checksum flag dropped without a clearing write");

   chk_ifault_sticky: assert property (@(posedge clk) disable iff (reset) // RQ4
      (status[BIT_IFAULT] && !(req.wrEn && hit && req.wrData[BIT_IFAULT])) |=> status[BIT_IFAULT])
      else $error("consistency flag dropped without a clearing write");

   chk_por_sticky: assert property (@(posedge clk) disable iff (reset) // RQ6
      (status[BIT_POR] && !(req.wrEn && hit && req.wrData[BIT_POR])) |=> status[BIT_POR])
      else $error("por flag dropped without a clearing write");

   chk_force_hold: assert property (@(posedge clk) disable iff (reset) // RQ2
      !(req.wrEn && hit) |=> $stable(status[BIT_FORCE]))
      else $error("force bit changed without a write");

   // an event and a clearing write in one cycle: the event must win
   sequence seqCrcCollide;
      events.crcError && req.wrEn && hit && req.wrData[BIT_CRC];
   endsequence
   chk_crc_set_wins: assert property (@(posedge clk) disable iff (reset) // RQ8
      seqCrcCollide |=> status[BIT_CRC])
      else $error("checksum event lost to a same-cycle clear");

   chk_ov_cause: assert property (@(posedge clk) disable iff (reset) // RQ10
      $rose(status[BIT_OV]) |-> $past(events.cell_overvoltage_flag))
      else $error("overvoltage flag set with no overvoltage event");

   chk_uv_cause: assert property (@(posedge clk) disable iff (reset) // RQ9
      $rose(status[BIT_UV]) |-> $past(events.cell_undervoltage_flag))
      else $error("undervoltage flag set with no undervoltage event");

   chk_crc_cause: assert property (@(posedge clk) disable iff (reset) // RQ8
      $rose(status[BIT_CRC]) |-> $past(events.crcError))
      else $error("checksum flag set with no checksum event");

   chk_ifault_cause: assert property (@(posedge clk) disable iff (reset) // RQ4
      $rose(status[BIT_IFAULT]) |-> $past(events.consistencyFail))
      else $error("consistency flag set with no consistency event");

   chk_por_cause: assert property (@(posedge clk) disable iff (reset) // RQ7
      $rose(status[BIT_POR]) |-> $past(porDone))
      else $error("por flag raised before the group load finished");

   chk_load_start: assert property (@(posedge clk) disable iff (reset) // RQ7
      (state == ST_LOAD) |=> groupLoadStart)
      else $error("group load not requested after reset");

   chk_load_pulse: assert property (@(posedge clk) disable iff (reset) // RQ7
      groupLoadStart |=> !groupLoadStart)
      else $error("group load request longer than one cycle");

   sequence seqReadHit;
      req.rdEn && hit;
   endsequence
   chk_read_value: assert property (@(posedge clk) disable iff (reset) // RQ1
      seqReadHit |=> (rdData == $past(status)))
      else $error("read data does not show the held flags");

   chk_fault_quiet: assert property (@(posedge clk) disable iff (reset) // RQ3
      (status == FSR_ZERO) |=> !faultOut)
      else $error("fault output high with no flag and no force");
endmodule

/* fsr_host_model.sv */
`timescale 1ns/1ns
module fsr_host_model
   import fsr_pkg::*;
(
   input  wire logic        clk,
   output fsr_pkg::fsr_req_t req,
   input  wire logic [7:0]  rdData,
   input  wire logic        rdValid
);
   initial req = '0;
   // one strobe per access, held until the sampling edge, then dropped
   task automatic access(input logic wr, input logic [7:0] a, d, output logic [7:0] q);
      @(posedge clk);
      req <= {wr, ~wr, a, d};
      @(posedge clk);
      req <= '0;
      #1 q = rdValid ? rdData : 8'hxx;
   endtask
endmodule

/* test_fsr_fault_status.sv */
`timescale 1ns/1ns
module test_fsr_fault_status;
   import fsr_pkg::*;
   logic        clk = 0, reset = 1, groupLoadDone = 0;
   logic        groupLoadStart, rdValid, faultOut;
   logic [7:0]  rdData, q;
   fsr_events_t events = '0;
   fsr_req_t    req;
   int          errTotal = 0, checks = 0;
   fsr_fault_status u_dut (.clk(clk), .reset(reset), .req(req), .events(events), .groupLoadDone(groupLoadDone),
      .groupLoadStart(groupLoadStart), .rdData(rdData), .rdValid(rdValid), .faultOut(faultOut));
   fsr_host_model u_host (.clk(clk), .req(req), .rdData(rdData), .rdValid(rdValid));
   initial forever #50 clk = ~clk;
   task automatic chk(input logic [7:0] got, exp);
      checks++;
      if (got !== exp) begin
         $display("BAD %0t got %h want %h", $time, got, exp);
         errTotal++;
      end
   endtask
   // writes land two edges before the read samples, so faultOut has settled
   task automatic rd(input logic [7:0] a, exp, input logic f);
      u_host.access(0, a, 8'h00, q);
      chk(q, exp);
      chk({7'h00, faultOut}, {7'h00, f});
   endtask
   task automatic w(input logic [7:0] a, d);
      u_host.access(1, a, d, q);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, errTotal);
      if (errTotal == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic t_por;
      for (int n = 0; groupLoadStart !== 1'b1; n++) begin
         if (n > 10) begin
            $display("BAD %0t no load request after reset", $time);
            errTotal++;
            stop_test;
         end
         @(posedge clk) #1;
      end
      rd(FSR_ADDR, FSR_ZERO, 0);
      chk({7'h00, groupLoadStart}, FSR_ZERO);
      @(posedge clk) groupLoadDone <= 1;
      @(posedge clk) groupLoadDone <= 0;
      rd(FSR_ADDR, FSR_RESET_VAL, 1);
      w(FSR_ADDR, 8'h08);
      rd(FSR_ADDR, FSR_ZERO, 0);
      $display("por test done");
   endtask
   task automatic t_events;
      logic [7:0] ex [4] = '{8'h01, 8'h02, 8'h04, 8'h20};
      for (int i = 0; i < 4; i++) begin
         @(posedge clk) events <= 4'b0001 << i;
         @(posedge clk) events <= '0;
         rd(FSR_ADDR, ex[i], 1);
         w(FSR_ADDR, FSR_W1C_MASK & ~ex[i]);
         rd(FSR_ADDR, ex[i], 1);
         w(FSR_ADDR, ex[i]);
         rd(FSR_ADDR, FSR_ZERO, 0);
      end
      $display("event test done");
   endtask
   task automatic t_force;
      w(FSR_ADDR, 8'h10);
      rd(FSR_ADDR, 8'h10, 1);
      w(FSR_ADDR, 8'hFF);
      rd(FSR_ADDR, 8'h10, 1);
      w(FSR_ADDR, 8'hC0);
      rd(FSR_ADDR, FSR_ZERO, 0);
      w(8'h22, 8'h10);
      rd(FSR_ADDR, FSR_ZERO, 0);
      rd(8'h22, FSR_ZERO, 0);
      $display("force test done");
   endtask
   // host reaction to a consistency failure: reset, reload, then see whether the flag returns
   task automatic t_recover;
      @(posedge clk) events <= 4'b1000;
      @(posedge clk) events <= '0;
      rd(FSR_ADDR, 8'h20, 1);
      @(posedge clk) reset <= 1;
      @(posedge clk) #1;
      chk({6'h00, rdValid, faultOut}, FSR_ZERO);
      repeat (3) @(posedge clk);
      reset <= 0;
      t_por;
      @(posedge clk) events <= 4'b1100;
      rd(FSR_ADDR, 8'h24, 1);
      w(FSR_ADDR, 8'h24);
      rd(FSR_ADDR, 8'h24, 1);
      @(posedge clk) events <= '0;
      w(FSR_ADDR, 8'h24);
      rd(FSR_ADDR, FSR_ZERO, 0);
      $display("recover test done");
   endtask
   initial begin
      repeat (20) @(posedge clk);
      reset <= 0;
      t_por;
      t_events;
      t_force;
      t_recover;
      stop_test;
   end
endmodule
